// *** hw/packet_tx_retry_sequencer.sv ***
// packet transmit sequencer: sensing, back-off, retries, extended receive
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module packet_tx_retry_sequencer
    import modem_seq_pkg::*;
#(
    parameter int AIR_BASE_CYC = AIR_BASE_CYC_DEF,
    parameter int AIR_BYTE_CYC = AIR_BYTE_CYC_DEF,
    parameter int ACK_DIRECT_CYC = ACK_DIRECT_CYC_DEF,
    parameter int ACK_REP_CYC = ACK_REP_CYC_DEF,
    parameter int SENSE_CYC = SENSE_CYC_DEF,
    parameter int BO1_CYC = BO1_CYC_DEF,
    parameter int BO2_CYC = BO2_CYC_DEF,
    parameter int BO3_CYC = BO3_CYC_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // radio side, asynchronous
    input wire logic carrier_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_seq_i,
    input wire logic [7:0] rx_len_i,
    input wire logic rx_relay_i,
    input wire logic ack_pre_i,
    output logic tx_en_o,
    output logic [1:0] tx_kind_o,
    output logic [7:0] tx_len_o,
    output logic tx_rep_o,
    // host side events
    output logic reply_valid_o,
    output logic [2:0] reply_code_o,
    output logic fwd_valid_o,
    output logic [7:0] fwd_seq_o
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SENSE,
        ST_BACKOFF,
        ST_TX,
        ST_ACKWAIT,
        ST_ANSWER
    } state_t;

    localparam int SYNC_W = 20;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [TMR_W-1:0] backoff_cyc(input logic [1:0] pick);
        case (pick)
            2'h0: backoff_cyc = {{(TMR_W-1){1'b0}}, 1'b1};
            2'h1: backoff_cyc = TMR_W'(BO1_CYC);
            2'h2: backoff_cyc = TMR_W'(BO2_CYC);
            default: backoff_cyc = TMR_W'(BO3_CYC);
        endcase
    endfunction

    // registers
    logic [2:0] mode_q;
    logic [7:0] ext_opt_q;
    logic [7:0] retry_cfg_q;
    logic [7:0] gap_q;
    logic [15:0] serial_q;
    logic ok_q;
    logic fail_q;
    logic err_q;

    // bus
    logic [7:0] addr_q;
    logic wr_pend_q;
    logic [31:0] rdata_q;
    logic addr_ph;

    // radio synchroniser
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    logic rxv_prev_q;
    logic ack_prev_q;
    logic carrier_s;
    logic rx_evt;
    logic ack_evt;
    logic [7:0] rx_seq_s;
    logic [7:0] rx_len_s;
    logic rx_relay_s;

    // sequencer
    state_t st_q;
    state_t st_d;
    logic [7:0] retry_q;
    logic [7:0] len_q;
    logic rep_q;
    logic relay_q;
    logic ret_sense_q;
    logic [1:0] kind_q;
    logic [7:0] last_seq_q;
    logic have_seq_q;
    logic tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic tmr_done;
    logic [1:0] pick;
    logic [TMR_W-1:0] air_cyc;

    // decoded events
    logic wr_cmd;
    logic wr_data;
    logic go_req;
    logic go_ok;
    logic data_err;
    logic ext_ok;
    logic rx_dup;
    logic take_rx;
    logic ev_ok;
    logic ev_fail;
    logic ev_fwd;
    logic start_relay;
    logic [2:0] ans_kind_sel;

    seq_timer #(
        .W(TMR_W)
    ) u_timer (
        .clk_i(clk_sys_i),
        .rstn_i(rstn_i),
        .load_i(tmr_load),
        .value_i(tmr_val),
        .done_o(tmr_done)
    );

    seq_lfsr u_lfsr (
        .clk_i(clk_sys_i),
        .rstn_i(rstn_i),
        .pick_o(pick)
    );

    // two flops before any logic reads the radio pins
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_q <= '0;
            s2_q <= '0;
            rxv_prev_q <= 1'b0;
            ack_prev_q <= 1'b0;
        end else begin
            s1_q <= {carrier_i, rx_valid_i, ack_pre_i, rx_relay_i, rx_seq_i, rx_len_i};
            s2_q <= s1_q;
            rxv_prev_q <= s2_q[18];
            ack_prev_q <= s2_q[17];
        end
    end

    // data is sampled with its strobe; the radio holds it while the strobe is high
    assign carrier_s = s2_q[19];
    assign rx_evt = s2_q[18] && !rxv_prev_q;
    assign ack_evt = s2_q[17] && !ack_prev_q;
    assign rx_relay_s = s2_q[16];
    assign rx_seq_s = s2_q[15:8];
    assign rx_len_s = s2_q[7:0];

    // zero wait state slave: read data is registered in the address phase
    assign addr_ph = hsel_i && htrans_i[1] && hready_i;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_q <= 8'h00;
            wr_pend_q <= 1'b0;
        end else begin
            addr_q <= haddr_i[7:0];
            wr_pend_q <= addr_ph && hwrite_i;
        end
    end

    // unmapped offsets read as zero
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= 32'h00000000;
        end else if (addr_ph && !hwrite_i) begin
            rdata_q <= 32'h00000000;
            if (hit(haddr_i[7:0], OFS_MODE)) begin
                rdata_q[2:0] <= mode_q;
            end
            if (hit(haddr_i[7:0], OFS_EXT_OPT)) begin
                rdata_q[7:0] <= ext_opt_q;
            end
            if (hit(haddr_i[7:0], OFS_RETRY)) begin
                rdata_q[7:0] <= retry_cfg_q;
            end
            if (hit(haddr_i[7:0], OFS_GAP)) begin
                rdata_q[7:0] <= gap_q;
            end
            if (hit(haddr_i[7:0], OFS_CMD)) begin
                rdata_q[8:0] <= {rep_q, len_q};
            end
            if (hit(haddr_i[7:0], OFS_STATUS)) begin
                rdata_q[23:0] <= {last_seq_q, err_q, fail_q, ok_q,
                                  (st_q != ST_IDLE), retry_q, 1'b0, st_q};
            end
            if (hit(haddr_i[7:0], OFS_SERIAL)) begin
                rdata_q[15:0] <= serial_q;
            end
        end
    end

    assign hrdata_o = rdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // write decode
    assign wr_cmd = wr_pend_q && hit(addr_q, OFS_CMD);
    assign wr_data = wr_pend_q && hit(addr_q, OFS_HOST_DATA);
    assign go_req = wr_cmd && hwdata_i[CMD_GO_BIT];
    assign go_ok = go_req && (st_q == ST_IDLE) && (hwdata_i[7:0] != 8'h00) &&
                   (mode_q == MODE_ADDRESSED || mode_q == MODE_HEADLESS);
    // header byte inside data is a command error unless a gap is set
    assign data_err = wr_data && (hwdata_i[7:0] == CMD_HEADER) && (gap_q == 8'h00);

    // configuration registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_q <= MODE_RST;
            ext_opt_q <= EXT_OPT_RST;
            retry_cfg_q <= RETRY_RST;
            gap_q <= GAP_RST;
            serial_q <= SERIAL_RST;
        end else if (wr_pend_q) begin
            if (hit(addr_q, OFS_MODE)) begin
                mode_q <= hwdata_i[2:0];
            end
            if (hit(addr_q, OFS_EXT_OPT)) begin
                ext_opt_q <= hwdata_i[7:0];
            end
            if (hit(addr_q, OFS_RETRY)) begin
                retry_cfg_q <= hwdata_i[7:0];
            end
            if (hit(addr_q, OFS_GAP)) begin
                gap_q <= hwdata_i[7:0];
            end
            // link framing is held for the serial port; it runs 300..115200 bps
            if (hit(addr_q, OFS_SERIAL)) begin
                serial_q <= hwdata_i[15:0];
            end
        end
    end

    // sticky status: a new event wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ok_q <= 1'b0;
            fail_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            if (ev_ok) begin
                ok_q <= 1'b1;
            end else if (wr_pend_q && hit(addr_q, OFS_STATUS) && hwdata_i[ST_OK_BIT]) begin
                ok_q <= 1'b0;
            end
            if (ev_fail) begin
                fail_q <= 1'b1;
            end else if (wr_pend_q && hit(addr_q, OFS_STATUS) && hwdata_i[ST_FAIL_BIT]) begin
                fail_q <= 1'b0;
            end
            if (data_err || (go_req && !go_ok)) begin
                err_q <= 1'b1;
            end else if (wr_pend_q && hit(addr_q, OFS_STATUS) && hwdata_i[ST_ERR_BIT]) begin
                err_q <= 1'b0;
            end
        end
    end

    // air time of the pending packet
    assign air_cyc = TMR_W'(AIR_BASE_CYC) + TMR_W'(len_q) * TMR_W'(AIR_BYTE_CYC);

    // extended receive needs the option bit and one of the two packet modes
    assign ext_ok = ext_opt_q[EXT_RX_BIT] &&
                    (mode_q == MODE_ADDRESSED || mode_q == MODE_HEADLESS);
    assign rx_dup = have_seq_q && (rx_seq_s == last_seq_q);
    assign start_relay = rx_evt && rx_relay_s && (mode_q == MODE_REPEATER);

    // sequencer next state
    always_comb begin
        st_d = st_q;
        tmr_load = 1'b0;
        tmr_val = '0;
        take_rx = 1'b0;
        ev_ok = 1'b0;
        ev_fail = 1'b0;
        ans_kind_sel = 3'h0;
        case (st_q)
            ST_IDLE: begin
                if (go_ok || start_relay) begin
                    st_d = ST_SENSE;
                    tmr_load = 1'b1;
                    tmr_val = TMR_W'(SENSE_CYC);
                end else if (rx_evt) begin
                    st_d = ST_ANSWER;
                    take_rx = 1'b1;
                    ans_kind_sel = 3'h1;
                    tmr_load = 1'b1;
                    tmr_val = TMR_W'(AIR_BASE_CYC);
                end
            end
            ST_SENSE: begin
                if (rx_evt && ext_ok) begin
                    st_d = ST_ANSWER;
                    take_rx = 1'b1;
                    ans_kind_sel = 3'h5;
                    tmr_load = 1'b1;
                    tmr_val = TMR_W'(AIR_BASE_CYC);
                end else if (carrier_s) begin
                    // a packet without extended receive is just carrier: the sequencer backs off, then senses again
                    st_d = ST_BACKOFF;
                    tmr_load = 1'b1;
                    tmr_val = backoff_cyc(pick);
                end else if (tmr_done) begin
                    st_d = ST_TX;
                    tmr_load = 1'b1;
                    tmr_val = air_cyc;
                end
            end
            ST_BACKOFF: begin
                if (tmr_done) begin
                    st_d = ST_SENSE;
                    tmr_load = 1'b1;
                    tmr_val = TMR_W'(SENSE_CYC);
                end
            end
            ST_TX: begin
                if (tmr_done) begin
                    st_d = ST_ACKWAIT;
                    tmr_load = 1'b1;
                    tmr_val = rep_q ? air_cyc + TMR_W'(ACK_REP_CYC)
                                    : TMR_W'(ACK_DIRECT_CYC);
                end
            end
            ST_ACKWAIT: begin
                if (ack_evt) begin
                    if (relay_q) begin
                        st_d = ST_ANSWER;
                        ans_kind_sel = 3'h1;
                        tmr_load = 1'b1;
                        tmr_val = TMR_W'(AIR_BASE_CYC);
                    end else begin
                        st_d = ST_IDLE;
                        ev_ok = 1'b1;
                    end
                end else if (tmr_done) begin
                    if (retry_q != 8'h00) begin
                        st_d = ST_BACKOFF;
                        tmr_load = 1'b1;
                        tmr_val = backoff_cyc(pick);
                    end else if (relay_q) begin
                        st_d = ST_ANSWER;
                        ans_kind_sel = 3'h2;
                        tmr_load = 1'b1;
                        tmr_val = TMR_W'(AIR_BASE_CYC);
                    end else begin
                        st_d = ST_IDLE;
                        ev_fail = 1'b1;
                    end
                end
            end
            ST_ANSWER: begin
                if (tmr_done) begin
                    st_d = ret_sense_q ? ST_SENSE : ST_IDLE;
                    tmr_load = ret_sense_q;
                    tmr_val = TMR_W'(SENSE_CYC);
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    assign ev_fwd = take_rx && !rx_dup && !rx_relay_s;

    // state register
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // pending packet, retry counter and answer kind
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            retry_q <= 8'h00;
            len_q <= 8'h00;
            rep_q <= 1'b0;
            relay_q <= 1'b0;
            ret_sense_q <= 1'b0;
            kind_q <= KIND_MSG;
        end else begin
            if (st_q == ST_IDLE && go_ok) begin
                retry_q <= retry_cfg_q;
                len_q <= hwdata_i[7:0];
                rep_q <= hwdata_i[CMD_REP_BIT];
                relay_q <= 1'b0;
            end else if (st_q == ST_IDLE && start_relay) begin
                retry_q <= retry_cfg_q;
                len_q <= rx_len_s;
                rep_q <= 1'b0;
                relay_q <= 1'b1;
            end else if (st_q == ST_ACKWAIT && st_d == ST_BACKOFF) begin
                retry_q <= retry_q - 8'h01;
            end
            if (ans_kind_sel != 3'h0) begin
                ret_sense_q <= ans_kind_sel[2];
                kind_q <= ans_kind_sel[1] ? KIND_NAK : KIND_ACK;
            end
            if (st_d == ST_SENSE || st_d == ST_IDLE) begin
                kind_q <= KIND_MSG;
            end
        end
    end

    // duplicate filter remembers the last delivered packet
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_seq_q <= 8'h00;
            have_seq_q <= 1'b0;
        end else if (ev_fwd) begin
            last_seq_q <= rx_seq_s;
            have_seq_q <= 1'b1;
        end
    end

    // radio outputs: on during packet and answer transmission
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_en_o <= 1'b0;
            tx_kind_o <= KIND_MSG;
            tx_len_o <= 8'h00;
            tx_rep_o <= 1'b0;
        end else begin
            tx_en_o <= (st_d == ST_TX) || (st_d == ST_ANSWER);
            tx_kind_o <= (st_d == ST_ANSWER) ? ((ans_kind_sel != 3'h0) ?
                         (ans_kind_sel[1] ? KIND_NAK : KIND_ACK) : kind_q) : KIND_MSG;
            tx_len_o <= len_q;
            tx_rep_o <= rep_q;
        end
    end

    // host replies: accepted first, forwarded messages, then success or failure
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reply_valid_o <= 1'b0;
            reply_code_o <= 3'h0;
        end else begin
            reply_valid_o <= go_ok || ev_ok || ev_fail || data_err || (go_req && !go_ok);
            if (ev_ok) begin
                reply_code_o <= RPL_SUCCESS;
            end else if (ev_fail) begin
                reply_code_o <= RPL_FAILURE;
            end else if (go_ok) begin
                reply_code_o <= RPL_ACCEPTED;
            end else if (data_err || go_req) begin
                reply_code_o <= RPL_CMD_ERROR;
            end
        end
    end

    // forwarded packet notice; inside a command it lands between the two replies
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fwd_valid_o <= 1'b0;
            fwd_seq_o <= 8'h00;
        end else begin
            fwd_valid_o <= ev_fwd;
            if (ev_fwd) begin
                fwd_seq_o <= rx_seq_s;
            end
        end
    end

endmodule

// *** hw/modem_seq_pkg.sv ***
// constants, register map and timing of the packet transmit and retry sequencer
package modem_seq_pkg;

    // clock and times in their own units
    localparam int CLK_NS = 40;
    localparam int AIR_BASE_NS = 7084000;
    localparam int AIR_BYTE_NS = 154000;
    localparam int ACK_DIRECT_NS = 5000000;
    localparam int ACK_REP_NS = 17200000;
    localparam int SENSE_NS = 3000000;
    localparam int BO1_NS = 3000000;
    localparam int BO2_NS = 6000000;
    localparam int BO3_NS = 10000000;

    // cycle counts, rounded up to whole cycles
    localparam int AIR_BASE_CYC_DEF = (AIR_BASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int AIR_BYTE_CYC_DEF = (AIR_BYTE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACK_DIRECT_CYC_DEF = (ACK_DIRECT_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACK_REP_CYC_DEF = (ACK_REP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SENSE_CYC_DEF = (SENSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int BO1_CYC_DEF = (BO1_NS + CLK_NS - 1) / CLK_NS;
    localparam int BO2_CYC_DEF = (BO2_NS + CLK_NS - 1) / CLK_NS;
    localparam int BO3_CYC_DEF = (BO3_NS + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 21;

    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_EXT_OPT = 8'h04;
    localparam logic [7:0] OFS_RETRY = 8'h08;
    localparam logic [7:0] OFS_GAP = 8'h0C;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam logic [7:0] OFS_HOST_DATA = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_SERIAL = 8'h1C;

    // fields
    localparam int EXT_RX_BIT = 3;
    localparam int CMD_REP_BIT = 8;
    localparam int CMD_GO_BIT = 9;
    localparam int ST_OK_BIT = 13;
    localparam int ST_FAIL_BIT = 14;
    localparam int ST_ERR_BIT = 15;

    // reset values
    localparam logic [2:0] MODE_RST = 3'h3;
    localparam logic [7:0] EXT_OPT_RST = 8'h00;
    localparam logic [7:0] RETRY_RST = 8'h03;
    localparam logic [7:0] GAP_RST = 8'h00;
    localparam logic [15:0] SERIAL_RST = 16'h0000;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    // operating modes and codes
    localparam logic [2:0] MODE_ADDRESSED = 3'h3;
    localparam logic [2:0] MODE_REPEATER = 3'h4;
    localparam logic [2:0] MODE_HEADLESS = 3'h5;
    localparam logic [7:0] CMD_HEADER = 8'h40;
    localparam logic [2:0] RPL_ACCEPTED = 3'h1;
    localparam logic [2:0] RPL_SUCCESS = 3'h2;
    localparam logic [2:0] RPL_FAILURE = 3'h3;
    localparam logic [2:0] RPL_CMD_ERROR = 3'h4;
    localparam logic [1:0] KIND_MSG = 2'h0;
    localparam logic [1:0] KIND_ACK = 2'h1;
    localparam logic [1:0] KIND_NAK = 2'h2;

endpackage

// *** hw/seq_timer.sv ***
// one-shot down counter giving a pulse a loaded number of cycles later
`timescale 1ns/1ps
module seq_timer #(
    parameter int W = 21
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input wire logic [W-1:0] value_i,
    output logic done_o
);
    logic [W-1:0] cnt_q;

    // a zero load never fires, so callers load at least one
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= value_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // decoded from the count, not registered: a registered pulse would stretch every phase by one
    assign done_o = (cnt_q == {{(W-1){1'b0}}, 1'b1});
endmodule

// *** hw/seq_lfsr.sv ***
// free running pseudo random source for the back-off choice
`timescale 1ns/1ps
module seq_lfsr
    import modem_seq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    output logic [1:0] pick_o
);
    logic [15:0] lfsr_q;

    // maximal length taps; runs every cycle so the choice depends on timing
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lfsr_q <= LFSR_SEED;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    assign pick_o = lfsr_q[1:0];
endmodule

// *** tb/seq_asserts.sv ***
// port checks for the packet transmit sequencer
`timescale 1ns/1ps
module seq_asserts
    import modem_seq_pkg::*;
#(
    parameter int AIR_BASE_CYC = 40,
    parameter int AIR_BYTE_CYC = 4
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic carrier_i,
    input wire logic ack_pre_i,
    input wire logic tx_en_o,
    input wire logic [1:0] tx_kind_o,
    input wire logic [7:0] tx_len_o,
    input wire logic reply_valid_o,
    input wire logic [2:0] reply_code_o,
    input wire logic fwd_valid_o,
    input wire logic [7:0] fwd_seq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    logic [15:0] on_q;
    logic [3:0] ago_q;
    // burst length, and age of the last preamble saturating so it never wraps
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            on_q <= 16'h0;
            ago_q <= 4'hF;
        end else begin
            on_q <= tx_en_o ? on_q + 16'h1 : 16'h0;
            ago_q <= ack_pre_i ? 4'h0 : ((ago_q == 4'hF) ? ago_q : ago_q + 4'h1);
        end
    end
    chk_air_time: assert property ($fell(tx_en_o) && $past(tx_kind_o) == KIND_MSG
        |-> on_q == AIR_BASE_CYC + $past(tx_len_o) * AIR_BYTE_CYC) else $error("air time");
    chk_ack_time: assert property ($fell(tx_en_o) && $past(tx_kind_o) == KIND_ACK
        |-> on_q == AIR_BASE_CYC) else $error("ack time");
    chk_ack_wait: assert property ($fell(tx_en_o) && $past(tx_kind_o) == KIND_MSG
        |-> !tx_en_o [*8]) else $error("resent early");
    chk_quiet_air: assert property ($rose(tx_en_o) && tx_kind_o == KIND_MSG
        |-> !$past(carrier_i, 5)) else $error("sent over carrier");
    chk_ok_preamble: assert property (reply_valid_o && reply_code_o == RPL_SUCCESS
        |-> ago_q < 4'h8) else $error("success without preamble");
    chk_fail_ends: assert property (reply_valid_o && reply_code_o == RPL_FAILURE
        |-> !tx_en_o [*8]) else $error("sent after failure");
    chk_fwd_new: assert property (fwd_valid_o |-> fwd_seq_o != $past(fwd_seq_o))
        else $error("copy forwarded");
    chk_fwd_pulse: assert property (fwd_valid_o |=> !fwd_valid_o) else $error("fwd");
    cover property (reply_valid_o && reply_code_o == RPL_SUCCESS);
    cover property (reply_valid_o && reply_code_o == RPL_FAILURE);
    cover property (fwd_valid_o);
endmodule
bind packet_tx_retry_sequencer seq_asserts #(.AIR_BASE_CYC(AIR_BASE_CYC),
    .AIR_BYTE_CYC(AIR_BYTE_CYC)) i_chk (.clk_sys_i, .rstn_i, .carrier_i, .ack_pre_i,
    .tx_en_o, .tx_kind_o, .tx_len_o, .reply_valid_o, .reply_code_o, .fwd_valid_o, .fwd_seq_o);

// *** tb/radio_peer.sv ***
// far radio that answers a sent packet with an ack preamble
`timescale 1ns/1ps
module radio_peer
    import modem_seq_pkg::*;
(
    input wire logic clk_i,
    input wire logic tx_en_i,
    input wire logic [1:0] tx_kind_i,
    input wire logic [7:0] delay_i,
    output logic ack_pre_o
);
    logic was_q = 1'b0;
    logic arm_q = 1'b0;
    logic [7:0] cnt_q = 8'h0;
    initial ack_pre_o = 1'b0;
    // delay 0 never answers, so the sender must time out
    always @(posedge clk_i) begin
        was_q <= tx_en_i && tx_kind_i == KIND_MSG;
        if (was_q && !tx_en_i && delay_i != 8'h0) begin
            arm_q <= 1'b1;
            cnt_q <= 8'h0;
        end else if (arm_q) begin
            cnt_q <= cnt_q + 8'h1;
            arm_q <= cnt_q != delay_i + 8'h4;
        end
        ack_pre_o <= arm_q && cnt_q >= delay_i && cnt_q < delay_i + 8'h4;
    end
endmodule

// *** tb/packet_tx_retry_sequencer_tb.sv ***
// self-checking bench for the packet transmit sequencer
`timescale 1ns/1ps
module packet_tx_retry_sequencer_tb;
    import modem_seq_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, car = 1'b0, rxv = 1'b0, txp = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
    logic [7:0] seq = 8'h0, dly = 8'h0, fseq, tlen;
    logic hready, tx_en, rv, fv, ack, trep, hresp;
    logic [1:0] kind;
    logic [2:0] code;
    logic [3:0] ev[$];
    int mismatches = 0, checks_done = 0, ntx = 0;
    always #20 clk_sys_i = ~clk_sys_i;
    packet_tx_retry_sequencer #(.AIR_BASE_CYC(40), .AIR_BYTE_CYC(4), .ACK_DIRECT_CYC(30),
        .ACK_REP_CYC(50), .SENSE_CYC(10), .BO1_CYC(5), .BO2_CYC(10), .BO3_CYC(20)) i_dut (
        .clk_sys_i, .rstn_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .carrier_i(car),
        .rx_valid_i(rxv), .rx_seq_i(seq), .rx_len_i(8'h2), .rx_relay_i(1'b0), .ack_pre_i(ack),
        .tx_en_o(tx_en), .tx_kind_o(kind), .tx_len_o(tlen), .tx_rep_o(trep), .reply_valid_o(rv),
        .reply_code_o(code), .fwd_valid_o(fv), .fwd_seq_o(fseq));
    radio_peer i_peer (.clk_i(clk_sys_i), .tx_en_i(tx_en), .tx_kind_i(kind), .delay_i(dly),
        .ack_pre_o(ack));
    // host event log: reply codes, 8 for a forwarded message; sent packets counted
    always @(posedge clk_sys_i) begin
        txp <= tx_en;
        if (tx_en === 1'b1 && !txp && kind === KIND_MSG) ntx++;
        if (fv === 1'b1) ev.push_back(4'h8);
        if (rv === 1'b1) ev.push_back({1'b0, code});
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // configure, send a two byte command, optionally collide, then judge the event order
    task run(input logic [2:0] md, input logic [7:0] ext, input logic [7:0] rt,
        input logic inj, input logic cr, input logic [7:0] dl, input logic [15:0] exp, int n);
        logic [15:0] got;
        got = 16'h0;
        ev.delete();
        ntx = 0;
        dly <= dl;
        car <= cr;
        bus(1'b1, OFS_MODE, {29'h0, md});
        bus(1'b1, OFS_EXT_OPT, {24'h0, ext});
        bus(1'b1, OFS_RETRY, {24'h0, rt});
        bus(1'b1, OFS_CMD, 32'h202);
        if (inj) begin
            seq <= seq + 8'h1;
            repeat (2) @(posedge clk_sys_i);
            rxv <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            rxv <= 1'b0;
            seq <= ~seq;
        end
        repeat (40) @(posedge clk_sys_i);
        if (cr) chk(ntx, 0);
        car <= 1'b0;
        for (int i = 0; i < 3000 && !(ev.size() > 0 && ev[$] inside {[2:4]}); i++)
            @(posedge clk_sys_i);
        foreach (ev[i]) got = {got[11:0], ev[i]};
        chk(got, exp);
        chk(ntx, n);
        chk({hresp, trep, tlen}, 32'h2);
        if (exp[7:4] == 4'h8) chk(fseq ^ seq, 8'hFF);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        bus(1'b0, OFS_MODE, 32'h0);
        chk(rd, {29'h0, MODE_RST});
        bus(1'b0, OFS_RETRY, 32'h0);
        chk(rd, {24'h0, RETRY_RST});
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        run(3'h3, 8'h00, 8'h2, 1'b0, 1'b0, 8'h5, 16'h12, 1);
        run(3'h3, 8'h00, 8'h1, 1'b0, 1'b0, 8'h0, 16'h13, 2);
        run(3'h3, 8'h00, 8'h2, 1'b0, 1'b1, 8'h5, 16'h12, 1);
        run(3'h3, 8'hF7, 8'h2, 1'b1, 1'b0, 8'h5, 16'h12, 1);
        run(3'h3, 8'h08, 8'h2, 1'b1, 1'b0, 8'h5, 16'h182, 1);
        run(3'h5, 8'h08, 8'h2, 1'b1, 1'b0, 8'h5, 16'h182, 1);
        run(3'h4, 8'h08, 8'h2, 1'b0, 1'b0, 8'h5, 16'h4, 0);
        ev.delete();
        bus(1'b1, OFS_HOST_DATA, {24'h0, CMD_HEADER});
        repeat (4) @(posedge clk_sys_i);
        chk(ev.size() == 1 ? ev[0] : 4'hF, {1'b0, RPL_CMD_ERROR});
        complete_run();
    end
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        mismatches++;
        complete_run();
    end
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
endmodule
